// [spu_top.sv]
// Purpose: System protection unit: watchdog, halt and bus monitors, periodic
//   interrupt timer and reset cause flags, reached over Avalon-MM.
// Assumes: 25 MHz clk; resetn is the power-on reset of this block.
// Notes: Word addressed slave; one wait cycle on every access.
// Summary of operation
// - Halt monitor reset sets halt cause flag.
// - Lost clock reference sets its cause flag.
// - Processor reset instruction sets its flag.
// - Test unit reset sets its cause flag.
// - Watchdog enable bit, resets to one.
// - Watchdog prescale bit divides by 512.
// - Prescale bits load inverted clock mode pin.
// - Three bits pick timeout exponent table.
// - Halt monitor works only when enabled.
// - Bus monitor times external cycles when enabled.
// - Bus timeout is 64, 32, 16, 8.
// - Level zero disables periodic interrupt; here it only idles irqLevel, the PIT status bit still sets.
// - Acknowledge returns the programmed vector.
// - Periodic timer: modulus, prescale, zero stops.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "spu_regs.svh"
module spu_top import spu_pkg::*; #(
  parameter int WD_CUT = 0, // Lowers every watchdog exponent for simulation.
  parameter int PRESCALE = `SPU_PRESCALE // Periodic timer prescale ratio.
) (
  input wire logic clk, // System clock, 25 MHz.
  input wire logic resetn, // Power-on reset, active low.
  input wire logic [19:0] address, // Avalon word address.
  input wire logic read, // Avalon read.
  input wire logic write, // Avalon write.
  input wire logic [31:0] writedata, // Avalon write data.
  input wire logic [3:0] byteenable, // Avalon byte enables.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon wait request.
  input wire logic crystalInput, // Crystal reference pin.
  input wire logic clockModePin, // Clock mode strap pin.
  input wire logic cpuHalted, // Processor is halted.
  input wire logic lossOfReference, // Clock unit lost its reference.
  input wire logic resetInstruction, // Processor ran its reset instruction.
  input wire logic testUnitReset, // Test unit requests reset.
  input wire logic extCycle, // Internal to external cycle active.
  input wire logic extCycleAck, // That cycle is acknowledged.
  input wire logic iackStrobe, // Interrupt acknowledge cycle.
  input wire logic [2:0] iackLevel, // Level being acknowledged.
  output logic busError, // Bus error pulse.
  output logic [2:0] irqLevel, // Periodic request level, zero idle.
  output logic [7:0] irqVector, // Vector for acknowledge.
  output logic vectorValid, // Vector valid pulse.
  output logic systemReset, // Generated system reset, active high.
  output logic irq // Level interrupt from status and mask.
);
  localparam int RST_CYC = (`SPU_RST_NS + `SPU_CLK_NS - 1) / `SPU_CLK_NS; // Reset pulse.

  // ==========================================================
  // Pin synchronisation and crystal tick.
  logic xtalS; // Synchronised crystal.
  logic modeS; // Synchronised clock mode pin.
  logic xtalPrev; // Crystal one cycle earlier.
  logic xtalTick; // Rising crystal edge.

  spu_sync #(.W(2)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({crystalInput, clockModePin}),
    .dout({xtalS, modeS})
  );

  // Remembers the crystal level for edge detection.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xtalPrev <= 1'b0;
    end else begin
      xtalPrev <= xtalS;
    end
  end
  assign xtalTick = xtalS && !xtalPrev;

  // ==========================================================
  // Avalon slave handshake.
  logic [31:0] rdMux; // Selected read value.
  logic [31:0] next_readdata; // Next read data.
  logic next_waitrequest; // Next wait request.
  logic wrEn; // Write takes effect this edge.
  logic svcWrite; // Low byte write to the service register.

  // Answers each request after one wait cycle.
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    if ((read || write) && waitrequest) begin
      next_waitrequest = 1'b0;
      if (read) begin
        next_readdata = rdMux;
      end
    end
  end

  // Registers the handshake outputs.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
    end
  end
  assign wrEn = write && !waitrequest;
  assign svcWrite = wrEn && byteenable[0] && (address == `SPU_IDX_SVC);

  // ==========================================================
  // Control registers.
  logic wdEn, wdPre, hmEn, bmEn, pitPre; // Control bits.
  logic [1:0] wdTim, bmTim, irqMask; // Timing fields and interrupt mask.
  logic [2:0] picLevel; // Periodic request level.
  logic [7:0] picVector, pitMod; // Vector and modulus.
  logic [1:0] strapWait; // Cycles until the strap is synchronised.
  logic next_wdEn, next_wdPre, next_hmEn, next_bmEn, next_pitPre;
  logic [1:0] next_wdTim, next_bmTim, next_irqMask, next_strapWait;
  logic [2:0] next_picLevel;
  logic [7:0] next_picVector, next_pitMod;
  logic hold; // Generated reset in progress.

  // Handles strap capture, generated reset and software writes.
  always_comb begin
    {next_wdEn, next_wdPre, next_wdTim, next_hmEn, next_bmEn, next_bmTim} =
      {wdEn, wdPre, wdTim, hmEn, bmEn, bmTim};
    {next_picLevel, next_picVector} = {picLevel, picVector};
    {next_pitPre, next_pitMod, next_irqMask} = {pitPre, pitMod, irqMask};
    next_strapWait = strapWait;
    if (hold) begin
      {next_wdEn, next_wdTim, next_hmEn, next_bmEn, next_bmTim} = {`SPU_RST_WDEN, 6'h0};
      {next_picLevel, next_picVector} = 11'(`SPU_RST_PIC);
      next_pitMod = 8'h0;
      next_irqMask = 2'h0;
      next_wdPre = !modeS;
      next_pitPre = !modeS;
    end else if (strapWait != 2'h0) begin
      // Waits for the synchroniser to hold the real strap level.
      next_strapWait = strapWait - 2'h1;
      if (strapWait == 2'h1) begin
        next_wdPre = !modeS;
        next_pitPre = !modeS;
      end
    end
    // A write landing in the strap cycle still takes effect, and it wins.
    if (!hold && wrEn) begin
      case (address)
        `SPU_IDX_PROT: begin
          if (byteenable[0]) begin
            {next_wdEn, next_wdPre, next_wdTim} = writedata[7:4];
            {next_hmEn, next_bmEn, next_bmTim} = writedata[3:0];
          end
        end
        `SPU_IDX_PIC: begin
          if (byteenable[0]) begin
            next_picVector = writedata[7:0];
          end
          if (byteenable[1]) begin
            next_picLevel = writedata[10:8];
          end
        end
        `SPU_IDX_PIT: begin
          if (byteenable[0]) begin
            next_pitMod = writedata[7:0];
          end
          if (byteenable[1]) begin
            next_pitPre = writedata[8];
          end
        end
        `SPU_IDX_IMSK: begin
          if (byteenable[0]) begin
            next_irqMask = writedata[1:0];
          end
        end
        default: begin
          // Other addresses leave control untouched.
        end
      endcase
    end
  end

  // Registers the control bits.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {wdEn, wdPre, wdTim, hmEn, bmEn, bmTim} <= {`SPU_RST_WDEN, 7'h0};
      {picLevel, picVector} <= 11'(`SPU_RST_PIC);
      {pitPre, pitMod, irqMask} <= 11'h0;
      strapWait <= 2'h3;
    end else begin
      {wdEn, wdPre, wdTim, hmEn, bmEn, bmTim} <=
        {next_wdEn, next_wdPre, next_wdTim, next_hmEn, next_bmEn, next_bmTim};
      {picLevel, picVector} <= {next_picLevel, next_picVector};
      {pitPre, pitMod, irqMask} <= {next_pitPre, next_pitMod, next_irqMask};
      strapWait <= next_strapWait;
    end
  end

  // ==========================================================
  // Software watchdog.
  logic [24:0] wdCnt, next_wdCnt; // Crystal ticks since service.
  logic svcArmed, next_svcArmed; // First service byte seen.
  logic [4:0] wdExp; // Divide count exponent.
  logic [24:0] wdMask; // Last count before timeout.
  logic wdFire; // Watchdog timeout.

  // Counts crystal ticks and restarts on a full service sequence.
  always_comb begin
    case ({wdPre, wdTim})
      3'h0: wdExp = 5'd9;
      3'h1: wdExp = 5'd11;
      3'h2: wdExp = 5'd13;
      3'h3: wdExp = 5'd15;
      3'h4: wdExp = 5'd18;
      3'h5: wdExp = 5'd20;
      3'h6: wdExp = 5'd22;
      default: wdExp = 5'd24;
    endcase
    wdMask = (25'h1 << (wdExp - 5'(WD_CUT))) - 25'h1;
    wdFire = 1'b0;
    next_wdCnt = wdCnt;
    next_svcArmed = svcArmed;
    if (hold || !wdEn) begin
      next_wdCnt = 25'h0;
      next_svcArmed = 1'b0;
    end else if (svcWrite && writedata[7:0] == `SPU_SVC_DONE && svcArmed) begin
      next_wdCnt = 25'h0;
      next_svcArmed = 1'b0;
    end else begin
      if (svcWrite && writedata[7:0] == `SPU_SVC_ARM) begin
        next_svcArmed = 1'b1;
      end
      if (xtalTick) begin
        wdFire = (wdCnt >= wdMask);
        next_wdCnt = wdFire ? 25'h0 : wdCnt + 25'h1;
      end
    end
  end

  // Registers the watchdog.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdCnt <= 25'h0;
      svcArmed <= 1'b0;
    end else begin
      wdCnt <= next_wdCnt;
      svcArmed <= next_svcArmed;
    end
  end

  // ==========================================================
  // Reset generator and cause flags.
  spu_rst_t rstState, next_rstState; // Reset generator state.
  logic [4:0] rstCnt, next_rstCnt; // Cycles left in the pulse.
  spu_byte_t cause, next_cause; // Cause of the last reset.
  logic next_systemReset; // Next reset output.
  logic haltFire; // Halt monitor trips.

  assign haltFire = hmEn && cpuHalted;

  // Records every source of a new reset and times the pulse.
  always_comb begin
    next_rstState = rstState;
    next_rstCnt = rstCnt;
    next_cause = cause;
    next_systemReset = systemReset;
    case (rstState)
      SPU_RUN: begin
        if (wdFire || haltFire || lossOfReference || resetInstruction || testUnitReset) begin
          next_cause = 8'h0;
          next_cause[`SPU_CAUSE_WDOG] = wdFire;
          next_cause[`SPU_CAUSE_HALT] = haltFire;
          next_cause[`SPU_CAUSE_LOSS] = lossOfReference;
          next_cause[`SPU_CAUSE_INSTR] = resetInstruction;
          next_cause[`SPU_CAUSE_TEST] = testUnitReset;
          next_rstCnt = 5'(RST_CYC - 1);
          next_rstState = SPU_HOLD;
          next_systemReset = 1'b1;
        end
      end
      SPU_HOLD: begin
        if (rstCnt == 5'h0) begin
          next_rstState = SPU_RUN;
          next_systemReset = 1'b0;
        end else begin
          next_rstCnt = rstCnt - 5'h1;
        end
      end
      default: begin
        next_rstState = SPU_RUN;
        next_systemReset = 1'b0;
      end
    endcase
  end

  // Registers the reset generator.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstState <= SPU_RUN;
      rstCnt <= 5'h0;
      cause <= `SPU_RST_CAUSE;
      systemReset <= 1'b0;
    end else begin
      rstState <= next_rstState;
      rstCnt <= next_rstCnt;
      cause <= next_cause;
      systemReset <= next_systemReset;
    end
  end
  assign hold = (rstState == SPU_HOLD);

  // ==========================================================
  // Bus monitor.
  logic [6:0] bmCnt, next_bmCnt; // Clocks of the current cycle.
  logic [6:0] bmLimit; // Selected timeout.
  logic bmActive; // Cycle is being timed.
  logic next_busError; // Next bus error.

  // Times unacknowledged external cycles and flags one error each.
  always_comb begin
    bmLimit = `SPU_BM_BASE >> bmTim;
    bmActive = bmEn && extCycle && !extCycleAck && !hold;
    next_busError = 1'b0;
    next_bmCnt = bmCnt;
    if (!bmActive) begin
      next_bmCnt = 7'h0;
    end else if (bmCnt == bmLimit - 7'h1) begin
      next_busError = 1'b1;
      next_bmCnt = bmLimit;
    end else if (bmCnt != bmLimit) begin
      next_bmCnt = bmCnt + 7'h1;
    end
  end

  // Registers the bus monitor.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bmCnt <= 7'h0;
      busError <= 1'b0;
    end else begin
      bmCnt <= next_bmCnt;
      busError <= next_busError;
    end
  end

  // ==========================================================
  // Periodic interrupt timer.
  logic pitTick; // Prescaled timer tick.
  logic [7:0] pitCnt, next_pitCnt; // Ticks left in the period.
  logic pitPend, next_pitPend; // Request outstanding.
  logic pitExpire; // Period ended.
  logic iackHit; // Acknowledge for this request.
  logic [2:0] next_irqLevel;
  logic [7:0] next_irqVector;
  logic next_vectorValid;

  spu_prescale #(.DIV(PRESCALE)) u_pitdiv (
    .clk(clk),
    .resetn(resetn),
    .tickIn(xtalTick),
    .bypass(!pitPre),
    .clear(pitMod == 8'h0),
    .tickOut(pitTick)
  );

  // Counts down the modulus, reloads it and raises the request.
  always_comb begin
    iackHit = iackStrobe && pitPend && (iackLevel == picLevel);
    pitExpire = pitTick && (pitCnt == 8'h1) && !hold;
    next_pitCnt = pitCnt;
    next_pitPend = pitPend && !iackHit;
    if (hold || pitMod == 8'h0) begin
      next_pitCnt = 8'h0;
    end else if (pitTick) begin
      next_pitCnt = (pitCnt <= 8'h1) ? pitMod : pitCnt - 8'h1;
    end
    if (pitExpire) begin
      next_pitPend = 1'b1;
    end
    if (hold || picLevel == 3'h0) begin
      next_pitPend = 1'b0;
    end
    next_irqLevel = next_pitPend ? picLevel : 3'h0;
    next_vectorValid = iackHit;
    next_irqVector = iackHit ? picVector : irqVector;
  end

  // Registers the periodic timer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pitCnt <= 8'h0;
      pitPend <= 1'b0;
      irqLevel <= 3'h0;
      irqVector <= 8'h0;
      vectorValid <= 1'b0;
    end else begin
      pitCnt <= next_pitCnt;
      pitPend <= next_pitPend;
      irqLevel <= next_irqLevel;
      irqVector <= next_irqVector;
      vectorValid <= next_vectorValid;
    end
  end

  // ==========================================================
  // Interrupt status, mask and read multiplexer.
  logic [1:0] ist, next_ist; // Sticky event bits.
  logic [1:0] istClr; // Write one to clear.
  logic next_irq;

  // Sets on events, clears on write one; a set wins.
  always_comb begin
    istClr = (wrEn && byteenable[0] && address == `SPU_IDX_IST) ? writedata[1:0] : 2'h0;
    next_ist = ist & ~istClr;
    next_ist[`SPU_IST_PIT] = next_ist[`SPU_IST_PIT] || pitExpire;
    next_ist[`SPU_IST_BUS] = next_ist[`SPU_IST_BUS] || next_busError;
    next_irq = |(next_ist & irqMask);
    case (address)
      `SPU_IDX_CAUSE: rdMux = {24'h0, cause};
      `SPU_IDX_PROT: rdMux = {24'h0, wdEn, wdPre, wdTim, hmEn, bmEn, bmTim};
      `SPU_IDX_PIC: rdMux = {21'h0, picLevel, picVector};
      `SPU_IDX_PIT: rdMux = {23'h0, pitPre, pitMod};
      `SPU_IDX_IST: rdMux = {30'h0, ist};
      `SPU_IDX_IMSK: rdMux = {30'h0, irqMask};
      default: rdMux = 32'h0;
    endcase
  end

  // Registers status and interrupt output.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist <= 2'h0;
      irq <= 1'b0;
    end else begin
      ist <= next_ist;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // Assertions.
  property p_wdog_cause;
    @(posedge clk) disable iff (!resetn)
    wdFire |=> systemReset && cause[`SPU_CAUSE_WDOG];
  endproperty
  a_wdog_cause: assert property (p_wdog_cause) else $error("watchdog cause lost");

  property p_halt_cause;
    @(posedge clk) disable iff (!resetn)
    (haltFire && !hold) |=> cause[`SPU_CAUSE_HALT] && hold;
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt cause lost");

  property p_loss_cause;
    @(posedge clk) disable iff (!resetn)
    (lossOfReference && !hold) |=> cause[`SPU_CAUSE_LOSS];
  endproperty
  a_loss_cause: assert property (p_loss_cause) else $error("loss cause lost");

  property p_instr_cause;
    @(posedge clk) disable iff (!resetn)
    (resetInstruction && !hold) |=> cause[`SPU_CAUSE_INSTR];
  endproperty
  a_instr_cause: assert property (p_instr_cause) else $error("instr cause lost");

  property p_test_cause;
    @(posedge clk) disable iff (!resetn)
    (testUnitReset && !hold) |=> cause[`SPU_CAUSE_TEST];
  endproperty
  a_test_cause: assert property (p_test_cause) else $error("test cause lost");

  property p_wdog_off;
    @(posedge clk) disable iff (!resetn)
    !wdEn |=> wdCnt == 25'h0;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("disabled watchdog counts");

  property p_bus_eight;
    @(posedge clk) disable iff (!resetn)
    !bmActive ##1 (bmActive && bmTim == 2'h3) [*8] |=> busError;
  endproperty
  a_bus_eight: assert property (p_bus_eight) else $error("bus timeout not 8");

  property p_bus_off;
    @(posedge clk) disable iff (!resetn)
    !bmEn |=> !busError;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus monitor off errs");

  property p_level_zero;
    @(posedge clk) disable iff (!resetn)
    picLevel == 3'h0 |=> irqLevel == 3'h0;
  endproperty
  a_level_zero: assert property (p_level_zero) else $error("level zero requests");

  property p_vector;
    @(posedge clk) disable iff (!resetn)
    vectorValid |-> irqVector == $past(picVector) && $past(iackStrobe);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");

  property p_mod_zero;
    @(posedge clk) disable iff (!resetn)
    pitMod == 8'h0 |=> pitCnt == 8'h0 && !pitExpire;
  endproperty
  a_mod_zero: assert property (p_mod_zero) else $error("stopped timer runs");
endmodule

// [spu_regs.svh]
// Purpose: Register indices, field positions, reset values and timing counts.
// Assumes: Indices are Avalon word addresses; byte address is four times the index.
// Notes: Included by the protection unit top level and its testbench.
`ifndef SPU_REGS_SVH
`define SPU_REGS_SVH
// ==========================================================
// Register word indices.
`define SPU_IDX_CAUSE 20'hffa07
`define SPU_IDX_PROT 20'hffa21
`define SPU_IDX_PIC 20'hffa22
`define SPU_IDX_PIT 20'hffa24
`define SPU_IDX_SVC 20'hffa27
`define SPU_IDX_IST 20'hffa40
`define SPU_IDX_IMSK 20'hffa41
// ==========================================================
// Reset cause bit positions.
`define SPU_CAUSE_POWER 6
`define SPU_CAUSE_WDOG 5
`define SPU_CAUSE_HALT 4
`define SPU_CAUSE_LOSS 2
`define SPU_CAUSE_INSTR 1
`define SPU_CAUSE_TEST 0
// ==========================================================
// Interrupt status bit positions.
`define SPU_IST_PIT 0
`define SPU_IST_BUS 1
// ==========================================================
// Reset values and constants.
`define SPU_RST_CAUSE 8'h40
`define SPU_RST_PIC 16'h000f
`define SPU_RST_WDEN 1'b1
`define SPU_SVC_ARM 8'h55
`define SPU_SVC_DONE 8'haa
`define SPU_PRESCALE 512
`define SPU_BM_BASE 7'h40
// ==========================================================
// Timing: generated reset pulse length.
`define SPU_CLK_NS 40
`define SPU_RST_NS 640
`endif

// [spu_pkg.sv]
// Purpose: Types shared by the protection unit files.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in spu_regs.svh.
package spu_pkg;
  // Reset generator states.
  typedef enum logic {SPU_RUN, SPU_HOLD} spu_rst_t;
  // One byte of register data.
  typedef logic [7:0] spu_byte_t;
endpackage

// [spu_sync.sv]
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module spu_sync #(
  parameter int W = 2
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [W-1:0] din, // Asynchronous inputs.
  output logic [W-1:0] dout // Synchronised inputs.
);
  // ==========================================================
  // Synchroniser stages.
  logic [W-1:0] stage1; // First stage, metastable.

  // Both stages shift on every edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// [spu_prescale.sv]
// Purpose: Optional divide-by-DIV of a tick enable.
// Assumes: tickIn is a one-cycle pulse on clk.
// Notes: With bypass high the tick passes undivided.
`timescale 1ns/1ps
module spu_prescale #(
  parameter int DIV = 512
) (
  input wire logic clk, // System clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic tickIn, // Undivided tick.
  input wire logic bypass, // High passes tickIn through.
  input wire logic clear, // Restarts the division.
  output logic tickOut // Divided tick, one cycle.
);
  // ==========================================================
  // Division counter.
  logic [$clog2(DIV)-1:0] cnt; // Ticks seen in this period.
  logic [$clog2(DIV)-1:0] next_cnt; // Next count.
  logic wrap; // Last tick of a period.

  // Counts ticks and wraps after DIV of them.
  always_comb begin
    wrap = (cnt == ($clog2(DIV))'(DIV - 1));
    next_cnt = cnt;
    if (clear || bypass) begin
      next_cnt = '0;
    end else if (tickIn) begin
      next_cnt = wrap ? '0 : cnt + 1'b1;
    end
    tickOut = bypass ? tickIn : (tickIn && wrap);
  end

  // Registers the count.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// [system_protection_unit_tb.sv]
// Purpose: Self-checking bench for the protection unit.
// Assumes: One wait cycle per access; no crystal ticks unless xtalRun.
// Notes: Read results are checked by a monitor from a queue.
`timescale 1ns/1ps
`include "spu_regs.svh"
module system_protection_unit_tb;
  // ==========================================================
  // Stimulus and observed signals.
  logic clk = 0, resetn = 0, read = 0, write = 0, xtalRun = 0;
  logic [19:0] address = 0;
  logic [31:0] writedata = 0, readdata, seed = 32'hc55166fd;
  logic crystalInput = 0, cpuHalted = 0, extCycle = 0, iackStrobe = 0, extCycleAck = 0;
  logic lossOfReference = 0, resetInstruction = 0, testUnitReset = 0, clockModePin = 0;
  logic [2:0] iackLevel = 0, irqLevel;
  logic [7:0] irqVector;
  logic waitrequest, busError, vectorValid, systemReset, irq;
  logic [31:0] expQ[$];
  int numErrors = 0, testsRun = 0, cycles = 0, n;
  // Short counts keep the watchdog and timer runs brief.
  spu_top #(.WD_CUT(6), .PRESCALE(4)) uut (.clk(clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'h3), .readdata(readdata), .waitrequest(waitrequest),
    .crystalInput(crystalInput), .clockModePin(clockModePin), .cpuHalted(cpuHalted),
    .lossOfReference(lossOfReference), .resetInstruction(resetInstruction),
    .testUnitReset(testUnitReset), .extCycle(extCycle), .extCycleAck(extCycleAck),
    .iackStrobe(iackStrobe), .iackLevel(iackLevel), .busError(busError),
    .irqLevel(irqLevel), .irqVector(irqVector), .vectorValid(vectorValid),
    .systemReset(systemReset), .irq(irq));
  // ==========================================================
  // Clock, crystal ticks every second cycle, and the hang limit.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (xtalRun) crystalInput <= ~crystalInput;
    cycles++;
    if (cycles == 40000) begin
      numErrors++;
      printVerdict();
    end
  end
  // Read monitor: the oldest expected word meets each read answer.
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0 && expQ.size() > 0) chk(readdata, expQ.pop_front());
  end
  // ==========================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    read <= 0;
    write <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(0, a, 0);
  endtask
  // Waits for a generated reset, then lets it finish.
  task automatic rstSeen;
    n = 0;
    while (systemReset !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(systemReset, 1);
    repeat (24) @(posedge clk);
  endtask
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    repeat (5) @(posedge clk);
    rd(`SPU_IDX_PROT, 32'hc0);
    rd(`SPU_IDX_PIC, 32'h000f);
    rd(20'h00000, 0);
    seed = lfsr(seed);
    bus(1, `SPU_IDX_PIC, {21'h0, 3'h5, seed[7:0]});
    rd(`SPU_IDX_PIC, {21'h0, 3'h5, seed[7:0]});
    $display("registers done");
    // Periodic timer, acknowledge, vector and interrupt.
    bus(1, `SPU_IDX_IMSK, 3);
    bus(1, `SPU_IDX_PIT, 32'h102);
    xtalRun <= 1;
    n = 0;
    while (irqLevel !== 3'h5 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(irqLevel, 5);
    chk(n > 20, 1);
    iackStrobe <= 1;
    iackLevel <= 5;
    @(posedge clk);
    iackStrobe <= 0;
    @(posedge clk);
    chk(vectorValid, 1);
    chk(irqVector, seed[7:0]);
    chk(irq, 1);
    bus(1, `SPU_IDX_PIC, 0);
    repeat (30) @(posedge clk);
    chk(irqLevel, 0);
    bus(1, `SPU_IDX_PIT, 0);
    xtalRun <= 0;
    bus(1, `SPU_IDX_IST, 3);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    $display("periodic done");
    // Bus monitor: each timing code, then disabled.
    for (int t = 0; t < 6; t++) begin
      bus(1, `SPU_IDX_PROT, (t < 4) ? (4 | t) : (t == 5) ? 7 : 0);
      extCycle <= 1;
      extCycleAck <= (t == 5);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (busError !== 1'b1 && n < 80);
      chk(n, (t < 4) ? (64 >> t) + 1 : 80);
      extCycle <= 0;
      extCycleAck <= 0;
      @(posedge clk);
    end
    chk(irq, 1);
    $display("bus monitor done");
    // Halt ignored while disabled, then the reset causes.
    cpuHalted <= 1;
    repeat (8) @(posedge clk);
    chk(systemReset, 0);
    cpuHalted <= 0;
    for (int i = 0; i < 3; i++) begin
      {lossOfReference, resetInstruction, testUnitReset} <= 3'b001 << i;
      @(posedge clk);
      {lossOfReference, resetInstruction, testUnitReset} <= 0;
      rstSeen();
      rd(`SPU_IDX_CAUSE, 32'h1 << i);
    end
    bus(1, `SPU_IDX_PROT, 8);
    cpuHalted <= 1;
    clockModePin <= 1;
    rstSeen();
    cpuHalted <= 0;
    rd(`SPU_IDX_CAUSE, 32'h10);
    rd(`SPU_IDX_PROT, 32'h80);
    // Watchdog unprescaled, shortest code, serviced, then left to run out.
    bus(1, `SPU_IDX_PROT, 32'h80);
    xtalRun <= 1;
    repeat (8) begin
      bus(1, `SPU_IDX_SVC, 32'h55);
      bus(1, `SPU_IDX_SVC, 32'haa);
    end
    rd(`SPU_IDX_CAUSE, 32'h10);
    rstSeen();
    xtalRun <= 0;
    rd(`SPU_IDX_CAUSE, 32'h20);
    $display("resets done");
    printVerdict();
  end
endmodule
